// file: lin_status_responder.sv
// get-status responder with error field, channel codes and apb registers
`timescale 1ns/10ps
`default_nettype none
`include "lin_status_defines.svh"
module lin_status_responder (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // protocol engine
  input wire logic header_valid,
  input wire logic [7:0] header_pid,
  input wire logic [3:0] frame_error,
  input wire logic tx_ready,
  output var logic tx_valid,
  output var logic [7:0] tx_data,
  output var logic tx_last,
  // driver sense pins
  input wire logic [7:0] channel_on,
  input wire logic [7:0] overcurrent_fault,
  input wire logic thermal_shutdown,
  input wire logic [1:0] diag_thermal,
  input wire logic [1:0] open_load_fault,
  // interrupt
  output var logic irq
);
  // merge error code keeping the higher ranked
  function automatic logic [2:0] err_max(input logic [2:0] a, input logic [2:0] b);
    err_max = (a > b) ? a : b;
  endfunction

  // code of the highest frame error in a pulse vector
  function automatic logic [2:0] err_of(input logic [3:0] e);
    if (e[3]) err_of = `ERR_PARITY;
    else if (e[2]) err_of = `ERR_FRAMING;
    else if (e[1]) err_of = `ERR_CHECKSUM;
    else if (e[0]) err_of = `ERR_DATA;
    else err_of = `ERR_NONE;
  endfunction

  // protected identifier with its two parity bits
  function automatic logic [7:0] pid_of(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    pid_of = {p1, p0, id};
  endfunction

  // add with carry wrap for the enhanced checksum
  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    csum_add = s[7:0] + {7'h00, s[8]};
  endfunction

  lin_status_pkg::sense_t sense_raw;
  lin_status_pkg::sense_t sense;
  lin_status_pkg::resp_state_t state;
  lin_status_pkg::resp_state_t next_state;
  lin_status_pkg::status_word_t snap;
  lin_status_pkg::status_word_t next_snap;
  logic [6:0] nad;
  logic [6:0] next_nad;
  logic [1:0] slot;
  logic [1:0] next_slot;
  logic [`EVENT_WIDTH-1:0] event_flags;
  logic [`EVENT_WIDTH-1:0] next_event_flags;
  logic [`EVENT_WIDTH-1:0] mask;
  logic [`EVENT_WIDTH-1:0] next_mask;
  logic [`EVENT_WIDTH-1:0] read_taken;
  logic [`EVENT_WIDTH-1:0] next_read_taken;
  logic [2:0] err_code;
  logic [2:0] next_err_code;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic [7:0] csum_acc;
  logic [7:0] next_csum_acc;
  logic [7:0] next_tx_data;
  logic next_tx_valid;
  logic next_tx_last;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic [15:0] chan_code;
  logic [4:0] app_code;
  logic [7:0] status_pid;
  logic nad_ok;
  logic hit;
  logic hs;
  logic apb_done;
  logic [31:0] read_value;
  logic read_ok;

  assign sense_raw = {channel_on, overcurrent_fault, thermal_shutdown, diag_thermal,
                      open_load_fault};

  bit_sync #(.WIDTH(`SENSE_WIDTH)) u_sense_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(sense_raw),
    .sync_out(sense)
  );

  // channel status codes and fault code of this device only
  always_comb begin
    chan_code = '0;
    for (int i = 0; i < 8; i++) begin
      logic diag;
      logic local_t;
      diag = (i == `DIAG_CH_A) || (i == `DIAG_CH_B);
      local_t = (i == `DIAG_CH_A) ? sense.local_hot[0] :
                (i == `DIAG_CH_B) ? sense.local_hot[1] : 1'b0;
      if (sense.trip[i] || local_t) begin
        chan_code[2*i +: 2] = `CODE_LATCHED;
      end else if (sense.on[i] && !sense.hot) begin
        chan_code[2*i +: 2] = `CODE_ON;
      end else if (diag && !sense.on[i] &&
                   sense.open_load[(i == `DIAG_CH_A) ? 0 : 1]) begin
        chan_code[2*i +: 2] = `CODE_OPEN_LOAD;
      end else begin
        chan_code[2*i +: 2] = `CODE_OFF;
      end
    end
    if (sense.hot) begin
      app_code = `APP_GLOBAL_HOT;
    end else if (sense.trip[`DIAG_CH_A] || sense.trip[`DIAG_CH_B] || (|sense.local_hot)) begin
      app_code = `APP_DIAG_FAULT;
    end else begin
      app_code = `APP_NONE;
    end
  end

  // identifier owned by node address and slot
  always_comb begin
    nad_ok = (nad[6:4] == `NAD_HIGH) && !nad[0] && (nad[3:1] != 3'h7);
    status_pid = pid_of({nad[3:1], 3'(`STATUS_ID_BASE + {1'b0, slot})});
    hit = header_valid && nad_ok && (header_pid == status_pid);
  end

  assign hs = tx_valid && tx_ready;

  // response sequencer
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_snap = snap;
    next_csum_acc = csum_acc;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    case (state)
      lin_status_pkg::ST_IDLE: begin
        if (hit) begin
          next_snap = '{chan: chan_code, app: app_code, err: err_code};
          next_state = lin_status_pkg::ST_SEND;
          next_idx = 4'h0;
          next_csum_acc = header_pid;
          next_tx_valid = 1'b1;
          next_tx_data = {err_code, app_code};
          next_tx_last = 1'b0;
        end
      end
      lin_status_pkg::ST_SEND: begin
        if (hs) begin
          next_csum_acc = csum_add(csum_acc, tx_data);
          next_idx = 4'(idx + 4'h1);
          if (idx == `CHECKSUM_IDX) begin
            next_state = lin_status_pkg::ST_IDLE;
            next_tx_valid = 1'b0;
            next_tx_last = 1'b0;
            next_tx_data = 8'h00;
          end else if (idx == `LAST_DATA_IDX) begin
            next_tx_data = ~csum_add(csum_acc, tx_data);
            next_tx_last = 1'b1;
          end else if (idx == 4'h0) begin
            next_tx_data = snap.chan[7:0];
          end else if (idx == 4'h1) begin
            next_tx_data = snap.chan[15:8];
          end else begin
            next_tx_data = 8'h00;
          end
        end
      end
      default: begin
        next_state = lin_status_pkg::ST_IDLE;
        next_tx_valid = 1'b0;
        next_tx_last = 1'b0;
      end
    endcase
  end

  // error field: rank merge, clear on send, new error wins
  always_comb begin
    next_err_code = err_code;
    if (hs && (idx == 4'h0) && (err_code == tx_data[7:5])) begin
      next_err_code = `ERR_NONE;
    end
    next_err_code = err_max(next_err_code, err_of(frame_error));
  end

  // apb access, events and interrupt
  always_comb begin
    read_value = 32'h0000_0000;
    read_ok = 1'b1;
    case (paddr)
      `CONFIG_OFFSET: read_value = {22'h0, slot, 1'b0, nad};
      `STATUS_OFFSET: read_value = {8'h00, chan_code, app_code, err_code};
      `EVENT_OFFSET: read_value = {30'h0, event_flags};
      `MASK_OFFSET: read_value = {30'h0, mask};
      default: read_ok = 1'b0;
    endcase
    apb_done = psel && penable && pready;
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_read_taken = read_taken;
    if (next_pready) begin
      next_prdata = pwrite ? 32'h0000_0000 : read_value;
      next_pslverr = !read_ok;
      next_read_taken = (!pwrite && paddr == `EVENT_OFFSET) ? event_flags : '0;
    end
    next_nad = nad;
    next_slot = slot;
    next_mask = mask;
    next_event_flags = event_flags;
    if (apb_done && pwrite && paddr == `CONFIG_OFFSET) begin
      next_nad = pwdata[`CFG_NAD_LSB +: 7];
      next_slot = pwdata[`CFG_SLOT_LSB +: 2];
    end
    if (apb_done && pwrite && paddr == `MASK_OFFSET) begin
      next_mask = pwdata[`EVENT_WIDTH-1:0];
    end
    if (apb_done && !pwrite && paddr == `EVENT_OFFSET) begin
      next_event_flags = event_flags & ~read_taken;
    end
    next_event_flags = next_event_flags |
                       {(|frame_error), (hs && idx == `CHECKSUM_IDX)};
    next_irq = |(next_event_flags & mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= lin_status_pkg::ST_IDLE;
      idx <= 4'h0;
      snap <= '0;
      csum_acc <= 8'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      err_code <= `ERR_RESET;
      nad <= `NAD_RESET;
      slot <= `SLOT_RESET;
      mask <= '0;
      event_flags <= '0;
      read_taken <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      snap <= next_snap;
      csum_acc <= next_csum_acc;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      err_code <= next_err_code;
      nad <= next_nad;
      slot <= next_slot;
      mask <= next_mask;
      event_flags <= next_event_flags;
      read_taken <= next_read_taken;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_byte1_layout;
    (state == lin_status_pkg::ST_IDLE) && hit |=>
      tx_valid && (tx_data[7:5] == $past(err_code)) && (tx_data[4:0] == $past(app_code));
  endproperty
  a_byte1_layout: assert property (p_byte1_layout) else $error("byte one layout wrong");

  property p_err_clear;
    hs && (idx == 4'h0) && (frame_error == 4'h0) && (err_code == tx_data[7:5]) |=>
      err_code == `ERR_NONE;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error field not cleared");

  property p_err_rank;
    frame_error[3] |=> err_code == `ERR_PARITY;
  endproperty
  a_err_rank: assert property (p_err_rank) else $error("parity error not ranked top");

  property p_null_bytes;
    hs && (idx >= 4'h3) && (idx <= `LAST_DATA_IDX) |-> tx_data == 8'h00;
  endproperty
  a_null_bytes: assert property (p_null_bytes) else $error("null byte not zero");

  property p_latched;
    sense.trip[0] |-> chan_code[1:0] == `CODE_LATCHED;
  endproperty
  a_latched: assert property (p_latched) else $error("overcurrent code wrong");

  property p_on_code;
    sense.on[1] && !sense.trip[1] && !sense.hot |-> chan_code[3:2] == `CODE_ON;
  endproperty
  a_on_code: assert property (p_on_code) else $error("on code wrong");

  property p_open_load;
    sense.open_load[0] && !sense.on[`DIAG_CH_A] && !sense.trip[`DIAG_CH_A] &&
      !sense.local_hot[0] ##1 !sense.open_load[0] && !sense.on[`DIAG_CH_A] &&
      !sense.trip[`DIAG_CH_A] && !sense.local_hot[0] |->
      chan_code[7:6] == `CODE_OFF;
  endproperty
  a_open_load: assert property (p_open_load) else $error("open load latched");

  property p_app_legal;
    !app_code[4] && !app_code[1] && !app_code[0] && !(app_code[3] && app_code[2]);
  endproperty
  a_app_legal: assert property (p_app_legal) else $error("unsupported fault code");

  property p_foreign_pid;
    (state == lin_status_pkg::ST_IDLE) && header_valid && (header_pid != status_pid) |=>
      !tx_valid;
  endproperty
  a_foreign_pid: assert property (p_foreign_pid) else $error("answered foreign pid");

  property p_checksum;
    hs && (idx == `CHECKSUM_IDX) |-> tx_last && (tx_data == ~csum_acc) ##1 !tx_valid;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum wrong");

  c_frame: cover property (hit ##[1:40] (hs && idx == `CHECKSUM_IDX));
  c_clear: cover property (hs && idx == 4'h0 && err_code != `ERR_NONE);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pready && pslverr);
endmodule // lin_status_responder
`default_nettype wire

// file: lin_status_defines.svh
// offsets, field positions, reset values and codes of the status responder
`ifndef LIN_STATUS_DEFINES_SVH
`define LIN_STATUS_DEFINES_SVH

`define CONFIG_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define EVENT_OFFSET 12'h008
`define MASK_OFFSET 12'h00c

`define CFG_NAD_LSB 0
`define CFG_SLOT_LSB 8
`define NAD_RESET 7'h60
`define SLOT_RESET 2'h0

`define ERR_NONE 3'h0
`define ERR_RESET 3'h1
`define ERR_DATA 3'h4
`define ERR_CHECKSUM 3'h5
`define ERR_FRAMING 3'h6
`define ERR_PARITY 3'h7

`define APP_NONE 5'h00
`define APP_GLOBAL_HOT 5'h04
`define APP_DIAG_FAULT 5'h08

`define CODE_OPEN_LOAD 2'h0
`define CODE_OFF 2'h1
`define CODE_ON 2'h2
`define CODE_LATCHED 2'h3

`define NAD_HIGH 3'h6
`define STATUS_ID_BASE 3'h2
`define DIAG_CH_A 3
`define DIAG_CH_B 7
`define LAST_DATA_IDX 4'h7
`define CHECKSUM_IDX 4'h8
`define EVENT_WIDTH 2
`define SENSE_WIDTH 21

`endif

// file: lin_status_pkg.sv
// types shared by the status responder files
package lin_status_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } resp_state_t;

  typedef struct packed {
    logic [7:0] on;
    logic [7:0] trip;
    logic hot;
    logic [1:0] local_hot;
    logic [1:0] open_load;
  } sense_t;

  typedef struct packed {
    logic [15:0] chan;
    logic [4:0] app;
    logic [2:0] err;
  } status_word_t;
endpackage

// file: bit_sync.sv
// two-flop synchroniser for the driver sense pins
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 21
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // bit_sync
`default_nettype wire

// file: lin_master_model.sv
// bus master model: issues status headers, frame errors and collects the response
`timescale 1ns/10ps
`default_nettype none
module lin_master_model (
  // clock
  input wire logic core_clk,
  // header side
  output var logic header_valid,
  output var logic [7:0] header_pid,
  output var logic [3:0] frame_error,
  // response side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output var logic tx_ready
);
  logic [7:0] rx [0:8];
  int n;

  initial begin
    header_valid = 1'b0;
    header_pid = 8'h00;
    frame_error = 4'h0;
    tx_ready = 1'b0;
    n = 0;
  end

  // header then byte collection; stall toggles ready every cycle
  task automatic request(input logic [7:0] pid, input logic stall);
    int k;
    n = 0;
    @(posedge core_clk);
    header_valid <= 1'b1;
    header_pid <= pid;
    @(posedge core_clk);
    header_valid <= 1'b0;
    header_pid <= ~pid;
    tx_ready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        if (n < 9) rx[n] = tx_data;
        n++;
        if (tx_last === 1'b1) break;
      end
      tx_ready <= stall ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
  endtask

  // one-cycle error report from the protocol engine
  task automatic flag_error(input logic [3:0] e);
    @(posedge core_clk);
    frame_error <= e;
    @(posedge core_clk);
    frame_error <= 4'h0;
  endtask
endmodule // lin_master_model
`default_nettype wire

// file: test_lin_status_responder.sv
// self-checking testbench of the status responder
`timescale 1ns/10ps
`default_nettype none
`include "lin_status_defines.svh"
module test_lin_status_responder;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, header_valid, tx_ready, tx_valid, tx_last;
  logic [7:0] header_pid, tx_data;
  logic [3:0] frame_error;
  logic [7:0] channel_on = 8'h00;
  logic [7:0] overcurrent_fault = 8'h00;
  logic thermal_shutdown = 1'b0;
  logic [1:0] diag_thermal = 2'h0;
  logic [1:0] open_load_fault = 2'h0;
  logic [31:0] r;
  logic e;
  int err_total = 0;
  int checked = 0;

  always #10 core_clk = ~core_clk;

  lin_status_responder i_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .header_valid(header_valid), .header_pid(header_pid),
    .frame_error(frame_error), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .channel_on(channel_on), .overcurrent_fault(overcurrent_fault),
    .thermal_shutdown(thermal_shutdown), .diag_thermal(diag_thermal),
    .open_load_fault(open_load_fault), .irq(irq));

  lin_master_model i_master (.core_clk(core_clk), .header_valid(header_valid),
    .header_pid(header_pid), .frame_error(frame_error), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  task test_done();
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "apb answer");
  endtask

  // request and compare all nine bytes, checksum worked out here
  task resp(input logic [7:0] pid, input logic stall, input logic [2:0] ec,
            input logic [4:0] app, input logic [7:0] b2, input logic [7:0] b3);
    logic [7:0] x [0:8];
    logic [8:0] s;
    int k;
    x[0] = {ec, app};
    x[1] = b2;
    x[2] = b3;
    for (k = 3; k < 8; k++) x[k] = 8'h00;
    s = {1'b0, pid};
    for (k = 0; k < 8; k++) begin
      s = s + {1'b0, x[k]};
      if (s[8]) s = s - 9'h0ff;
    end
    x[8] = ~s[7:0];
    i_master.request(pid, stall);
    chk(32'(i_master.n), 32'd9, "byte count");
    for (k = 0; k < 9; k++) chk({24'h0, i_master.rx[k]}, {24'h0, x[k]}, "response byte");
  endtask

  task quiet(input logic [7:0] pid);
    i_master.request(pid, 1'b0);
    chk(32'(i_master.n), 32'd0, "answer to foreign identifier");
  endtask

  task sense(input logic [7:0] on, input logic [7:0] oc, input logic t,
             input logic [1:0] dt, input logic [1:0] ol);
    @(posedge core_clk);
    channel_on <= on;
    overcurrent_fault <= oc;
    thermal_shutdown <= t;
    diag_thermal <= dt;
    open_load_fault <= ol;
    repeat (5) @(posedge core_clk);
  endtask

  task t_after_reset();
    resp(8'h42, 1'b0, `ERR_RESET, `APP_NONE, 8'h55, 8'h55);
    resp(8'h42, 1'b1, `ERR_NONE, `APP_NONE, 8'h55, 8'h55);
  endtask

  task t_registers();
    apb(`CONFIG_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h60, "config reset value");
    apb(`STATUS_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h555500, "status register");
    apb(12'h010, 1'b0, 32'h0);
    chk({r[30:0], e}, 32'h1, "unmapped access");
    apb(`EVENT_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h1, "events after two responses");
    apb(`MASK_OFFSET, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq while idle");
    resp(8'h42, 1'b0, `ERR_NONE, `APP_NONE, 8'h55, 8'h55);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq on response");
    apb(`EVENT_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h1, "response event");
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    apb(`MASK_OFFSET, 1'b1, 32'h2);
    apb(`MASK_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h2, "mask readback");
    i_master.flag_error(4'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq on frame error");
    apb(`EVENT_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h2, "frame error event");
    resp(8'h42, 1'b0, `ERR_DATA, `APP_NONE, 8'h55, 8'h55);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "masked response event");
    apb(`MASK_OFFSET, 1'b1, 32'h0);
  endtask

  task t_errors();
    for (int i = 0; i < 4; i++) begin
      i_master.flag_error(4'(1 << i));
      resp(8'h42, 1'b0, 3'(4 + i), `APP_NONE, 8'h55, 8'h55);
    end
    i_master.flag_error(4'h1);
    i_master.flag_error(4'h2);
    resp(8'h42, 1'b0, `ERR_CHECKSUM, `APP_NONE, 8'h55, 8'h55);
    i_master.flag_error(4'h8);
    i_master.flag_error(4'h1);
    resp(8'h42, 1'b1, `ERR_PARITY, `APP_NONE, 8'h55, 8'h55);
  endtask

  task t_channels();
    sense(8'h32, 8'h80, 1'b0, 2'h0, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_DIAG_FAULT, 8'h59, 8'hda);
    sense(8'h00, 8'h00, 1'b0, 2'h0, 2'h3);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_NONE, 8'h15, 8'h15);
    sense(8'h00, 8'h00, 1'b0, 2'h0, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_NONE, 8'h55, 8'h55);
    sense(8'hff, 8'h00, 1'b1, 2'h0, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_GLOBAL_HOT, 8'h55, 8'h55);
    sense(8'hff, 8'h00, 1'b0, 2'h1, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_DIAG_FAULT, 8'hea, 8'haa);
    sense(8'hff, 8'h00, 1'b0, 2'h2, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_DIAG_FAULT, 8'haa, 8'hea);
    sense(8'hff, 8'h01, 1'b0, 2'h0, 2'h3);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_NONE, 8'hab, 8'haa);
    sense(8'hff, 8'h80, 1'b1, 2'h0, 2'h0);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_GLOBAL_HOT, 8'h55, 8'hd5);
    sense(8'h00, 8'h00, 1'b0, 2'h0, 2'h0);
  endtask

  task t_address();
    logic [5:0] id;
    for (int a = 0; a < 7; a++) begin
      for (int s = 0; s < 4; s++) begin
        id = {3'(a), 3'(2 + s)};
        apb(`CONFIG_OFFSET, 1'b1, {22'h0, 2'(s), 1'b0, 7'(7'h60 + 2 * a)});
        resp(pid_of(id), 1'b0, `ERR_NONE, `APP_NONE, 8'h55, 8'h55);
        quiet(pid_of(id ^ 6'h01));
      end
    end
    apb(`CONFIG_OFFSET, 1'b1, 32'h36e);
    quiet(pid_of(6'h3d));
    apb(`CONFIG_OFFSET, 1'b1, 32'h06f);
    quiet(pid_of(6'h3a));
    quiet(8'h42);
    apb(`CONFIG_OFFSET, 1'b1, 32'h060);
    resp(8'h42, 1'b0, `ERR_NONE, `APP_NONE, 8'h55, 8'h55);
  endtask

  // reset in mid-run brings back the reset code and the default address
  task t_reset();
    apb(`CONFIG_OFFSET, 1'b1, 32'h26a);
    i_master.flag_error(4'h8);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(`CONFIG_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h60, "config after reset");
    resp(8'h42, 1'b1, `ERR_RESET, `APP_NONE, 8'h55, 8'h55);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_after_reset();
    t_registers();
    t_errors();
    t_channels();
    t_address();
    t_reset();
    test_done();
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule // test_lin_status_responder
`default_nettype wire
